// [hdl/ctps_timers.sv]
// Two prescaled timers with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "ctps_map.svh"
module ctps_timers (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Timer pins
  input wire logic event_i,
  input wire logic meas_i,
  output logic a_out_o,
  output logic b_out_o
);
  ctps_pkg::ctps_core_t q;
  ctps_pkg::ctps_core_t d;
  logic [7:0] a_pre, a_cnt, b_pre, b_cnt;
  logic a_pre_uf, a_cnt_uf, b_pre_uf, b_cnt_uf;
  logic a_stat, b_stat, os_flag;
  logic ev_edge, a_tick, b_tick, a_run, b_run;
  logic a_meas, b_shot, b_reload, b_kill, os_kill;
  logic wr, wr_a_pre, wr_a_cnt, wr_b_pre, wr_b_per;
  logic [7:0] wd, rb;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic src_tick(input logic [1:0] sel, input logic [4:0] div,
                                    input logic alt);
    case (sel)
      2'h0: src_tick = 1'b1;
      2'h1: src_tick = (div[2:0] == `CTPS_DIV8_TAP);
      2'h2: src_tick = (div == `CTPS_DIV32_TAP);
      default: src_tick = alt;
    endcase
  endfunction

  function automatic logic hit(input logic w, input logic [7:0] adr,
                               input logic [7:0] ofs);
    hit = w && (adr == ofs);
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // A write lands on the edge at which the master sees ack high.
  assign wr = cyc_i & stb_i & we_i & q.ack & sel_i[0];
  assign wd = dat_i[7:0];
  assign wr_a_pre = hit(wr, adr_i, `CTPS_OFS_A_PRE);
  assign wr_a_cnt = hit(wr, adr_i, `CTPS_OFS_A_CNT);
  assign wr_b_pre = hit(wr, adr_i, `CTPS_OFS_B_PRE);
  assign wr_b_per = hit(wr, adr_i, `CTPS_OFS_B_PER);
  assign ack_o = q.ack;
  assign dat_o = q.dat;

  // ----------------------------------------
  // Count sources and run gates
  // ----------------------------------------
  assign ev_edge = event_i & ~q.ev_last;
  assign a_tick = (q.a_mode == ctps_pkg::CTPS_A_EVENT) ? ev_edge :
                  src_tick(q.a_src, q.div, ev_edge);
  assign b_tick = src_tick(q.b_src, q.div, a_cnt_uf);
  assign a_meas = (q.a_mode == ctps_pkg::CTPS_A_WIDTH) ||
                  (q.a_mode == ctps_pkg::CTPS_A_PERIOD);
  assign b_shot = (q.b_mode == ctps_pkg::CTPS_B_ONESHOT) ||
                  (q.b_mode == ctps_pkg::CTPS_B_WAIT);
  assign a_run = a_stat & ((q.a_mode != ctps_pkg::CTPS_A_WIDTH) | meas_i);
  assign b_run = b_stat & (~b_shot | os_flag);

  assign b_kill = hit(wr, adr_i, `CTPS_OFS_B_CTRL) & wd[`CTPS_BIT_HALT];
  assign b_reload = b_shot & ((hit(wr, adr_i, `CTPS_OFS_B_CTRL) & q.b_start &
                     ~wd[`CTPS_BIT_START]) |
                    (hit(wr, adr_i, `CTPS_OFS_B_OS) & wd[`CTPS_BIT_OS_HALT]));
  assign os_kill = b_kill | b_reload |
                   (b_cnt_uf & ((q.b_mode == ctps_pkg::CTPS_B_ONESHOT) |
                   ((q.b_mode == ctps_pkg::CTPS_B_WAIT) & q.b_phase)));

  assign a_out_o = q.a_out;
  assign b_out_o = b_shot ? (os_flag & ((q.b_mode != ctps_pkg::CTPS_B_WAIT) |
                   q.b_phase)) : q.b_out;

  // ----------------------------------------
  // Timer cores
  // ----------------------------------------
  ctps_ticker u_a_tick (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .tick_i(a_tick), .run_i(a_run), .reload_i(1'b0),
    .wr_pre_i(wr_a_pre), .wr_cnt_i(wr_a_cnt), .din_i(wd),
    .pre_o(a_pre), .cnt_o(a_cnt), .pre_uf_o(a_pre_uf), .cnt_uf_o(a_cnt_uf)
  );

  ctps_ticker u_b_tick (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .tick_i(b_tick), .run_i(b_run), .reload_i(b_reload),
    .wr_pre_i(wr_b_pre), .wr_cnt_i(wr_b_per), .din_i(wd),
    .pre_o(b_pre), .cnt_o(b_cnt), .pre_uf_o(b_pre_uf), .cnt_uf_o(b_cnt_uf)
  );

  ctps_sync #(.STAGES(1)) u_a_sync (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .tick_i(a_tick), .req_i(q.a_start), .kill_i(1'b0), .flag_o(a_stat)
  );

  ctps_sync #(.STAGES(2)) u_b_sync (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .tick_i(b_tick), .req_i(q.b_start), .kill_i(b_kill), .flag_o(b_stat)
  );

  ctps_sync #(.STAGES(2)) u_os_sync (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .tick_i(b_tick), .req_i(q.os_tgt), .kill_i(os_kill), .flag_o(os_flag)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // each byte read on its own
  always_comb begin
    rb = 8'h00;
    case (adr_i)
      `CTPS_OFS_A_CTRL: begin
        rb[`CTPS_BIT_START] = q.a_start;
        rb[`CTPS_BIT_STAT] = a_stat;
        rb[`CTPS_BIT_EDGE] = q.a_edge;
        rb[`CTPS_BIT_UDF] = q.a_udf;
      end
      `CTPS_OFS_A_MODE: rb = {2'h0, q.a_src, 1'b0, q.a_mode};
      `CTPS_OFS_A_PRE: rb = a_pre;
      `CTPS_OFS_A_CNT: rb = a_cnt;
      `CTPS_OFS_B_CTRL: begin
        rb[`CTPS_BIT_START] = q.b_start;
        rb[`CTPS_BIT_STAT] = b_stat;
      end
      `CTPS_OFS_B_OS: rb[`CTPS_BIT_OS_STAT] = os_flag;
      `CTPS_OFS_B_MODE: rb = {2'h0, q.b_src, 2'h0, q.b_mode};
      `CTPS_OFS_B_PRE: rb = b_pre;
      `CTPS_OFS_B_PER: rb = b_cnt;
      default: rb = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.div = q.div + 5'h01;
    d.ev_last = event_i;
    d.ack = cyc_i & stb_i & ~q.ack;
    if (cyc_i & stb_i & ~q.ack) begin
      d.dat = {24'h000000, rb};
    end

    // First timer control and mode writes.
    if (hit(wr, adr_i, `CTPS_OFS_A_CTRL)) begin
      d.a_start = wd[`CTPS_BIT_START];
      if (!wd[`CTPS_BIT_EDGE]) begin
        d.a_edge = 1'b0;
      end
      if (!wd[`CTPS_BIT_UDF]) begin
        d.a_udf = 1'b0;
      end
    end
    if (hit(wr, adr_i, `CTPS_OFS_A_MODE)) begin
      d.a_mode = ctps_pkg::ctps_a_mode_t'(wd[`CTPS_MODE_LSB +: 3]);
      d.a_src = wd[`CTPS_SRC_LSB +: 2];
    end

    if (a_pre_uf) begin
      d.a_last = meas_i;
      if (a_meas && ((q.a_mode == ctps_pkg::CTPS_A_WIDTH) ?
          (q.a_last & ~meas_i) : (~q.a_last & meas_i))) begin
        d.a_edge = 1'b1;
      end
    end
    if (a_cnt_uf) begin
      if (a_meas) begin
        d.a_udf = 1'b1;
      end
      if (q.a_mode == ctps_pkg::CTPS_A_PULSE) begin
        d.a_out = ~q.a_out;
      end
    end

    // Second timer control, one-shot and mode writes.
    if (hit(wr, adr_i, `CTPS_OFS_B_CTRL)) begin
      d.b_start = wd[`CTPS_BIT_START] & ~wd[`CTPS_BIT_HALT];
    end
    if (hit(wr, adr_i, `CTPS_OFS_B_OS)) begin
      if (wd[`CTPS_BIT_OS_HALT]) begin
        d.os_tgt = 1'b0;
      end else if (wd[`CTPS_BIT_OS_BEGIN]) begin
        d.os_tgt = 1'b1;
        d.b_phase = 1'b0;
      end
    end
    if (hit(wr, adr_i, `CTPS_OFS_B_MODE)) begin
      d.b_mode = ctps_pkg::ctps_b_mode_t'(wd[`CTPS_MODE_LSB +: 2]);
      d.b_src = wd[`CTPS_SRC_LSB +: 2];
    end
    if (b_reload | b_kill) begin
      d.os_tgt = 1'b0;
      d.b_phase = 1'b0;
    end
    if (b_cnt_uf) begin
      if (q.b_mode == ctps_pkg::CTPS_B_WAVE) begin
        d.b_out = ~q.b_out;
      end
      if (os_kill) begin
        d.os_tgt = 1'b0;
        d.b_phase = 1'b0;
      end else if (q.b_mode == ctps_pkg::CTPS_B_WAIT) begin
        d.b_phase = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // both timers reset stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{ack: 1'b0, dat: 32'h00000000, div: 5'h00, ev_last: 1'b0,
             a_start: 1'b0, a_edge: 1'b0, a_udf: 1'b0,
             a_mode: ctps_pkg::CTPS_A_TIMER, a_src: 2'h0, a_last: 1'b0,
             a_out: 1'b0, b_start: 1'b0, b_mode: ctps_pkg::CTPS_B_TIMER,
             b_src: 2'h0, os_tgt: 1'b0, b_phase: 1'b0, b_out: 1'b0};
    end else if (ce_i) begin
      q <= d;
    end
  end
endmodule

// [hdl/ctps_map.svh]
// Register offsets, field positions and reset values of the timer pair.
`ifndef CTPS_MAP_SVH
`define CTPS_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CTPS_OFS_A_CTRL 8'h00
`define CTPS_OFS_A_MODE 8'h04
`define CTPS_OFS_A_PRE 8'h08
`define CTPS_OFS_A_CNT 8'h0C
`define CTPS_OFS_B_CTRL 8'h10
`define CTPS_OFS_B_OS 8'h14
`define CTPS_OFS_B_MODE 8'h18
`define CTPS_OFS_B_PRE 8'h1C
`define CTPS_OFS_B_PER 8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTPS_BIT_START 0
`define CTPS_BIT_STAT 1
`define CTPS_BIT_HALT 2
`define CTPS_BIT_EDGE 4
`define CTPS_BIT_UDF 5
`define CTPS_BIT_OS_BEGIN 0
`define CTPS_BIT_OS_HALT 1
`define CTPS_BIT_OS_STAT 2
`define CTPS_MODE_LSB 0
`define CTPS_SRC_LSB 4
// ----------------------------------------
// Reset values and divider taps
// ----------------------------------------
`define CTPS_PRE_RST 8'hFF
`define CTPS_CNT_RST 8'hFF
`define CTPS_DIV8_TAP 3'h7
`define CTPS_DIV32_TAP 5'h1F
`endif

// [hdl/ctps_pkg.sv]
// Types shared by the timer pair modules.
package ctps_pkg;
  typedef enum logic [2:0] {
    CTPS_A_TIMER = 3'h0,
    CTPS_A_PULSE = 3'h1,
    CTPS_A_EVENT = 3'h2,
    CTPS_A_WIDTH = 3'h3,
    CTPS_A_PERIOD = 3'h4
  } ctps_a_mode_t;

  typedef enum logic [1:0] {
    CTPS_B_TIMER = 2'h0,
    CTPS_B_WAVE = 2'h1,
    CTPS_B_ONESHOT = 2'h2,
    CTPS_B_WAIT = 2'h3
  } ctps_b_mode_t;

  typedef struct packed {
    logic [7:0] pre_rl;
    logic [7:0] pre;
    logic [7:0] cnt_rl;
    logic [7:0] cnt;
  } ctps_tick_t;

  typedef struct packed {
    logic [1:0] pipe;
  } ctps_sync_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [4:0] div;
    logic ev_last;
    logic a_start;
    logic a_edge;
    logic a_udf;
    ctps_a_mode_t a_mode;
    logic [1:0] a_src;
    logic a_last;
    logic a_out;
    logic b_start;
    ctps_b_mode_t b_mode;
    logic [1:0] b_src;
    logic os_tgt;
    logic b_phase;
    logic b_out;
  } ctps_core_t;
endpackage

// [hdl/ctps_ticker.sv]
// Prescaler and main down-counter with their reload registers.
`timescale 1ns/1ps
`include "ctps_map.svh"
module ctps_ticker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic reload_i,
  input wire logic wr_pre_i,
  input wire logic wr_cnt_i,
  input wire logic [7:0] din_i,
  // State
  output logic [7:0] pre_o,
  output logic [7:0] cnt_o,
  output logic pre_uf_o,
  output logic cnt_uf_o
);
  ctps_pkg::ctps_tick_t q;
  ctps_pkg::ctps_tick_t d;
  logic step;

  assign step = run_i & tick_i;
  assign pre_o = q.pre;
  assign cnt_o = q.cnt;
  assign pre_uf_o = step && (q.pre == 8'h00);
  assign cnt_uf_o = pre_uf_o && (q.cnt == 8'h00);

  always_comb begin
    d = q;
    if (step) begin
      d.pre = pre_uf_o ? q.pre_rl : q.pre - 8'h01;
    end
    if (pre_uf_o) begin
      d.cnt = cnt_uf_o ? q.cnt_rl : q.cnt - 8'h01;
    end
    if (reload_i) begin
      d.pre = q.pre_rl;
      d.cnt = q.cnt_rl;
    end
    if (wr_pre_i) begin
      d.pre_rl = din_i;
      d.pre = din_i;
    end
    if (wr_cnt_i) begin
      d.cnt_rl = din_i;
      d.cnt = din_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{pre_rl: `CTPS_PRE_RST, pre: `CTPS_PRE_RST,
             cnt_rl: `CTPS_CNT_RST, cnt: `CTPS_CNT_RST};
    end else if (ce_i) begin
      q <= d;
    end
  end
endmodule

// [hdl/ctps_sync.sv]
// Moves a request level into the count-source domain over one or two ticks.
`timescale 1ns/1ps
module ctps_sync #(
  parameter int STAGES = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Request side
  input wire logic tick_i,
  input wire logic req_i,
  input wire logic kill_i,
  // Status
  output logic flag_o
);
  ctps_pkg::ctps_sync_t q;
  ctps_pkg::ctps_sync_t d;

  assign flag_o = q.pipe[STAGES-1];

  always_comb begin
    d = q;
    if (tick_i) begin
      d.pipe = {q.pipe[0], req_i};
    end
    // Kill acts at once, without waiting for a tick.
    if (kill_i) begin
      d.pipe = 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{pipe: 2'h0};
    end else if (ce_i) begin
      q <= d;
    end
  end
endmodule

// [test/ctps_checker.sv]
// Concurrent checks on the register bus and timer outputs.
`timescale 1ns/1ps
`include "ctps_map.svh"
module ctps_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Timer pins
  input wire logic event_i,
  input wire logic meas_i,
  input wire logic a_out_o,
  input wire logic b_out_o
);
  logic req;
  logic rd;
  logic wr;
  logic a_start_q;
  logic b_halt_q;
  assign req = cyc_i && stb_i && !ack_o && ce_i;
  assign rd = req && !we_i;
  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  // ----------------------------------------
  // Mirrors of the start and forced-halt writes
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_start_q <= 1'b0;
      b_halt_q <= 1'b0;
    end else begin
      if (wr && adr_i == `CTPS_OFS_A_CTRL) begin
        a_start_q <= dat_i[0];
      end
      if (wr && adr_i == `CTPS_OFS_B_CTRL) begin
        b_halt_q <= dat_i[2] || (b_halt_q && !dat_i[0]);
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (req |=> ack_o)
    else $error("request was not acknowledged");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_read_width: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data wider than one byte");
  a_reset_quiet: assert property ($fell(rst_i) |->
    !ack_o && dat_o == 32'h0 && !a_out_o && !b_out_o)
    else $error("outputs not idle after reset");
  a_unmapped_zero: assert property (rd && adr_i > 8'h20 |=> dat_o == 32'h0)
    else $error("unmapped read returned data");
  a_start_echo: assert property (rd && adr_i == `CTPS_OFS_A_CTRL |=>
    dat_o[0] == a_start_q)
    else $error("first start bit read back wrong");
  a_halt_clears: assert property (rd && adr_i == `CTPS_OFS_B_CTRL && b_halt_q |=>
    dat_o[1:0] == 2'h0)
    else $error("second timer still running after forced halt");
endmodule
bind ctps_timers ctps_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .event_i(event_i), .meas_i(meas_i), .a_out_o(a_out_o), .b_out_o(b_out_o)
);

// [test/testbench.sv]
// Self-checking bench for the timer pair over its Wishbone port.
`timescale 1ns/1ps
`include "ctps_map.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic event_i = 1'b0;
  logic meas_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic a_out_o;
  logic b_out_o;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h3795;
  always #50 clk_i = ~clk_i;
  ctps_timers u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .event_i(event_i), .meas_i(meas_i), .a_out_o(a_out_o), .b_out_o(b_out_o)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  // Counts clock cycles between two changes of a timer output.
  task automatic per_chk(input logic b, input int n);
    int c;
    logic v;
    c = 0;
    v = b ? b_out_o : a_out_o;
    while ((b ? b_out_o : a_out_o) === v) @(posedge clk_i);
    v = b ? b_out_o : a_out_o;
    while ((b ? b_out_o : a_out_o) === v) begin
      @(posedge clk_i);
      c++;
    end
    chk(c, n);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      chk(dat_o, exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`CTPS_OFS_A_CTRL, 8'h00);
    rd(`CTPS_OFS_A_CNT, 8'hFF);
    rd(`CTPS_OFS_B_CTRL, 8'h00);
    rd(`CTPS_OFS_B_PER, 8'hFF);
    rd(`CTPS_OFS_B_OS, 8'h00);
    rd(8'h24, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      event_i <= seed[5];
      wr(`CTPS_OFS_A_PRE, seed[7:0]);
      wr(`CTPS_OFS_B_PRE, seed[15:8]);
      rd(`CTPS_OFS_A_PRE, seed[7:0]);
      rd(`CTPS_OFS_B_PRE, seed[15:8]);
    end
    bus(1'b1, `CTPS_OFS_A_PRE, 8'h00, 4'h0);
    rd(`CTPS_OFS_A_PRE, seed[7:0]);
    wr(`CTPS_OFS_A_MODE, 8'h01);
    wr(`CTPS_OFS_A_PRE, 8'h01);
    wr(`CTPS_OFS_A_CNT, 8'h02);
    rd(`CTPS_OFS_A_CNT, 8'h02);
    wr(`CTPS_OFS_A_CTRL, 8'h01);
    rd(`CTPS_OFS_A_CTRL, 8'h03);
    per_chk(1'b0, 6);
    wr(`CTPS_OFS_A_CTRL, 8'h00);
    rd(`CTPS_OFS_A_CTRL, 8'h00);
    wr(`CTPS_OFS_A_MODE, 8'h04);
    wr(`CTPS_OFS_A_CTRL, 8'h00);
    wr(`CTPS_OFS_A_PRE, 8'h00);
    wr(`CTPS_OFS_A_CNT, 8'h03);
    wr(`CTPS_OFS_A_CTRL, 8'h01);
    repeat (4) @(posedge clk_i);
    meas_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    wr(`CTPS_OFS_A_CTRL, 8'h30);
    rd(`CTPS_OFS_A_CTRL, 8'h30);
    wr(`CTPS_OFS_A_CTRL, 8'h20);
    rd(`CTPS_OFS_A_CTRL, 8'h20);
    wr(`CTPS_OFS_A_CTRL, 8'h00);
    rd(`CTPS_OFS_A_CTRL, 8'h00);
    wr(`CTPS_OFS_B_MODE, 8'h01);
    wr(`CTPS_OFS_B_PRE, 8'h00);
    wr(`CTPS_OFS_B_PER, 8'h04);
    wr(`CTPS_OFS_B_CTRL, 8'h01);
    rd(`CTPS_OFS_B_CTRL, 8'h03);
    per_chk(1'b1, 5);
    wr(`CTPS_OFS_B_CTRL, 8'h04);
    rd(`CTPS_OFS_B_CTRL, 8'h00);
    wr(`CTPS_OFS_B_MODE, 8'h02);
    wr(`CTPS_OFS_B_PER, 8'h40);
    wr(`CTPS_OFS_B_CTRL, 8'h01);
    wr(`CTPS_OFS_B_OS, 8'h01);
    rd(`CTPS_OFS_B_OS, 8'h04);
    chk({31'h0, b_out_o}, 32'h1);
    wr(`CTPS_OFS_B_OS, 8'h02);
    rd(`CTPS_OFS_B_PER, 8'h40);
    rd(`CTPS_OFS_B_OS, 8'h00);
    wr(`CTPS_OFS_B_OS, 8'h01);
    wr(`CTPS_OFS_B_CTRL, 8'h00);
    rd(`CTPS_OFS_B_PER, 8'h40);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    finish_test();
  end
endmodule
